// [rtl/dkhrp_consts.vh]
`ifndef DKHRP_CONSTS_VH
`define DKHRP_CONSTS_VH
// register select codes on address bits 3..1
`define DKHRP_SEL_CSR      3'h0
`define DKHRP_SEL_BAR      3'h1
`define DKHRP_SEL_DAR      3'h2
`define DKHRP_SEL_MPR      3'h3
`define DKHRP_SEL_BAE      3'h4
// command/status fields
`define DKHRP_CSR_DRIVE_READY_BIT     0
`define DKHRP_CSR_FUNC_LO  1
`define DKHRP_CSR_FUNC_HI  3
`define DKHRP_CSR_EXT_LO   4
`define DKHRP_CSR_EXT_HI   5
`define DKHRP_CSR_IE       6
`define DKHRP_CSR_CONTROLLER_READY_FLAG     7
`define DKHRP_CSR_OPI      10
`define DKHRP_CSR_DCRC     11
`define DKHRP_CSR_NXM      13
`define DKHRP_CSR_ERR      15
// addressing modes
`define DKHRP_MODE_16      2'h0
`define DKHRP_MODE_18      2'h1
`define DKHRP_MODE_22      2'h2
// crc
`define DKHRP_CRC_POLY     16'h8005
`define DKHRP_CRC_INIT     16'h0000
`define DKHRP_ZERO16       16'h0000
`define DKHRP_ONE16        16'h0001
`define DKHRP_BIT_LAST     4'hF
`define DKHRP_BIT_FIRST    4'h0
`endif

// [rtl/dkhrp_port.v]
// Contract
// RULE1 - five host registers; extension for wide mode
// RULE2 - host writes command/status register last
// RULE3 - selectable 16, 18 or 22 bit addressing
// RULE4 - host loads low and extension address
// RULE5 - 18-bit bits via extension or csr
// RULE6 - csr write starts microsequencer routine
// RULE7 - dma read parity error aborts command
// RULE8 - crc appended after written data
// RULE9 - read crc mismatch sets crc flag
// RULE10 - 256 by 16-bit fifo buffer
// RULE11 - serialise writes, deserialise reads
// RULE12 - latch select bits on sync, decode
// RULE13 - slave reply for every register access
// RULE14 - ready flag sampled by master reply
// RULE15 - ready flag only when command accepted
// RULE16 - master asserts bank select in address
// RULE17 - separate transmit and receive controls
// RULE18 - registers use internal tristate bus; code selects them with a case multiplexer into o_bus_data
// RULE19 - low address is 16-bit loadable counter
// RULE20 - extension 6 bits from bus 0-5
// RULE21 - csr 5:4 and extension 1:0 shared
// RULE22 - csr drive_ready_bit, function, ie, ready fields
// RULE23 - address increments, carries into extension
// RULE24 - reads have no side effects
`include "dkhrp_consts.vh"
module dkhrp_port #(
  parameter FIFO_DEPTH = 256,
  parameter FIFO_AW    = 8
) (
  input  wire        i_clk_sys,
  input  wire        i_rst,
  input  wire        i_sync,
  input  wire        i_bank_sel_n,
  input  wire        i_din,
  input  wire        i_dout,
  input  wire        i_master_reply_sample,
  input  wire [15:0] i_bus_data,
  input  wire [1:0]  i_addr_mode,
  input  wire        i_drive_ready_bit,
  input  wire        i_dma_word_done,
  input  wire        i_dma_rd_valid,
  input  wire [17:0] i_dma_rd_data,
  input  wire        i_dma_rd_parity_err,
  input  wire        i_seq_done,
  input  wire        i_wr_active,
  input  wire        i_wr_bit_en,
  input  wire        i_rd_active,
  input  wire        i_rd_bit_en,
  input  wire        i_rd_bit,
  input  wire        i_rd_field_end,
  input  wire        i_rd_is_header,
  input  wire        i_fifo_pop,
  output reg  [15:0] o_bus_data,
  output wire        o_bus_data_oe,
  output reg         o_slave_reply_internal,
  output reg         o_transceiver_transmit_ctl,
  output reg         o_transceiver_receive_ctl,
  output reg         o_slave_register_enable,
  output reg         o_seq_start,
  output reg  [2:0]  o_command_function_code,
  output reg         o_cmd_abort,
  output wire [21:0] o_dma_address,
  output reg         o_wr_bit,
  output reg         o_wr_crc_phase,
  output wire [15:0] o_fifo_head,
  output wire        o_fifo_empty,
  output wire        o_fifo_full
);

////////////////////////////////////////////////////////////////////////////////
reg  [2:0]  register_select_bits;
reg         sel_valid;
reg         controller_ready_flag;
reg         interrupt_enable_bit;
reg  [15:0] dma_start_address_low;
reg  [5:0]  dma_address_extension;
reg  [15:0] disk_sector_address_register;
reg  [15:0] multipurpose_register;
reg         crc_err_flag;
reg         hdr_flag;
reg         par_err_flag;
reg         din_q;
reg         dout_q;
reg         sync_q;
reg  [15:0] fifo_mem [0:FIFO_DEPTH-1];
reg  [FIFO_AW-1:0] fifo_rd_ptr;
reg  [FIFO_AW-1:0] fifo_wr_ptr;
reg  [FIFO_AW:0]   fifo_count;
reg  [15:0] wr_shift;
reg  [3:0]  wr_bit_cnt;
reg  [15:0] rd_shift;
reg  [3:0]  rd_bit_cnt;
reg  [15:0] crc_wr;
reg  [15:0] crc_rd;
reg  [15:0] next_read_data;
wire [15:0] command_status_register;
wire        sel_active;
wire        rd_strobe;
wire        wr_strobe;
wire        wr_csr;
wire        wr_bar;
wire        wr_dar;
wire        wr_mpr;
wire        wr_bae;
wire        fifo_push;
wire        fifo_pop;
wire        wr_word_pop;
wire        rd_word_push;
wire [15:0] rd_word;
wire [21:0] addr_next;
////////////////////////////////////////////////////////////////////////////////
function [15:0] crc_step;
  input [15:0] crc;
  input        bit_in;
  begin
    if (crc[15] ^ bit_in)
      crc_step = {crc[14:0], 1'b0} ^ `DKHRP_CRC_POLY;
    else
      crc_step = {crc[14:0], 1'b0};
  end
endfunction
////////////////////////////////////////////////////////////////////////////////
// address phase: latch select bits on sync, valid only when bank select low and code is at most BAE
always @(posedge i_clk_sys or posedge i_rst) begin
  if (i_rst) begin
    register_select_bits <= 3'h0;
    sel_valid            <= 1'b0;
  end else if (i_sync && !sync_q) begin
    register_select_bits <= i_bus_data[3:1]; // RULE12
    sel_valid            <= !i_bank_sel_n && (i_bus_data[3:1] <=
                            `DKHRP_SEL_BAE); // RULE16 RULE1
  end else if (!i_sync) begin
    sel_valid <= 1'b0;
  end
end

assign sel_active = sel_valid && i_sync;
always @(posedge i_clk_sys or posedge i_rst) begin
  if (i_rst) begin
    din_q  <= 1'b0;
    dout_q <= 1'b0;
    sync_q <= 1'b0;
  end else begin
    din_q  <= i_din;
    dout_q <= i_dout;
    sync_q <= i_sync;
  end
end
assign rd_strobe = sel_active && i_din && !din_q;
assign wr_strobe = sel_active && i_dout && !dout_q;
assign wr_csr = wr_strobe && register_select_bits == `DKHRP_SEL_CSR;
assign wr_bar = wr_strobe && register_select_bits == `DKHRP_SEL_BAR;
assign wr_dar = wr_strobe && register_select_bits == `DKHRP_SEL_DAR;
assign wr_mpr = wr_strobe && register_select_bits == `DKHRP_SEL_MPR;
assign wr_bae = wr_strobe && register_select_bits == `DKHRP_SEL_BAE;

// reply and transceiver steering
always @(posedge i_clk_sys or posedge i_rst) begin
  if (i_rst) begin
    o_slave_reply_internal     <= 1'b0;
    o_transceiver_transmit_ctl <= 1'b0;
    o_transceiver_receive_ctl  <= 1'b0;
    o_slave_register_enable    <= 1'b0;
  end else begin
    o_slave_reply_internal     <= sel_active && (i_din || i_dout); // RULE13
    o_transceiver_transmit_ctl <= sel_active && i_din; // RULE17
    o_transceiver_receive_ctl  <= !(sel_active && i_din); // RULE17
    if (i_master_reply_sample)
      o_slave_register_enable <= controller_ready_flag; // RULE14
  end
end

////////////////////////////////////////////////////////////////////////////////
assign command_status_register = {
  crc_err_flag || par_err_flag, 1'b0, par_err_flag, 1'b0, // RULE22
  crc_err_flag, (crc_err_flag && hdr_flag) || par_err_flag, 2'b00, // RULE9
  controller_ready_flag, interrupt_enable_bit,
  dma_address_extension[1:0], o_command_function_code, // RULE21
  i_drive_ready_bit};
always @* begin
  next_read_data = `DKHRP_ZERO16;
  case (register_select_bits)
    `DKHRP_SEL_CSR: next_read_data = command_status_register; // RULE18
    `DKHRP_SEL_BAR: next_read_data = dma_start_address_low;
    `DKHRP_SEL_DAR: next_read_data = disk_sector_address_register;
    `DKHRP_SEL_MPR: next_read_data = multipurpose_register;
    `DKHRP_SEL_BAE: next_read_data = {10'h000, dma_address_extension};
    default:        next_read_data = `DKHRP_ZERO16;
  endcase
end

always @(posedge i_clk_sys or posedge i_rst) begin
  if (i_rst)
    o_bus_data <= `DKHRP_ZERO16;
  else if (rd_strobe)
    o_bus_data <= next_read_data; // RULE24
end
assign o_bus_data_oe = o_transceiver_transmit_ctl;
////////////////////////////////////////////////////////////////////////////////
assign addr_next = {dma_address_extension, dma_start_address_low} +
                   22'h000002;
always @(posedge i_clk_sys or posedge i_rst) begin
  if (i_rst) begin
    dma_start_address_low        <= `DKHRP_ZERO16;
    dma_address_extension        <= 6'h00;
    disk_sector_address_register <= `DKHRP_ZERO16;
    multipurpose_register        <= `DKHRP_ZERO16;
    o_command_function_code      <= 3'h0;
    interrupt_enable_bit         <= 1'b0;
  end else begin
    if (wr_bar)
      dma_start_address_low <= i_bus_data; // RULE19 RULE4
    else if (i_dma_word_done)
      dma_start_address_low <= addr_next[15:0]; // RULE23
    if (wr_bae && i_addr_mode == `DKHRP_MODE_22)
      dma_address_extension <= i_bus_data[5:0]; // RULE20
    else if (wr_bae && i_addr_mode == `DKHRP_MODE_18)
      dma_address_extension[1:0] <= i_bus_data[1:0]; // RULE5
    else if (wr_csr && i_addr_mode != `DKHRP_MODE_16)
      dma_address_extension[1:0] <=
        i_bus_data[`DKHRP_CSR_EXT_HI:`DKHRP_CSR_EXT_LO]; // RULE5 RULE21
    else if (i_dma_word_done && i_addr_mode != `DKHRP_MODE_16)
      dma_address_extension <= addr_next[21:16]; // RULE23
    if (wr_dar)
      disk_sector_address_register <= i_bus_data;
    if (wr_mpr)
      multipurpose_register <= i_bus_data;
    if (wr_csr) begin
      o_command_function_code <=
        i_bus_data[`DKHRP_CSR_FUNC_HI:`DKHRP_CSR_FUNC_LO];
      interrupt_enable_bit <= i_bus_data[`DKHRP_CSR_IE];
    end
  end
end

// address width follows the selected mode
assign o_dma_address =
  (i_addr_mode == `DKHRP_MODE_16) ? {6'h00, dma_start_address_low} :
  (i_addr_mode == `DKHRP_MODE_18) ?
    {4'h0, dma_address_extension[1:0], dma_start_address_low} :
    {dma_address_extension, dma_start_address_low}; // RULE3
////////////////////////////////////////////////////////////////////////////////
// command launch, ready flag and error flags
always @(posedge i_clk_sys or posedge i_rst) begin
  if (i_rst) begin
    controller_ready_flag <= 1'b1;
    o_seq_start           <= 1'b0;
    o_cmd_abort           <= 1'b0;
    par_err_flag          <= 1'b0;
    crc_err_flag          <= 1'b0;
    hdr_flag              <= 1'b0;
  end else begin
    o_seq_start <= 1'b0;
    o_cmd_abort <= 1'b0;
    if (wr_csr && !i_bus_data[`DKHRP_CSR_CONTROLLER_READY_FLAG] && controller_ready_flag) begin
      controller_ready_flag <= 1'b0; // RULE15 RULE2
      o_seq_start           <= 1'b1; // RULE6
      par_err_flag          <= 1'b0;
      crc_err_flag          <= 1'b0;
      hdr_flag              <= 1'b0;
    end
    if (i_dma_rd_valid && i_dma_rd_parity_err && !controller_ready_flag) begin
      par_err_flag          <= 1'b1; // RULE7
      o_cmd_abort           <= 1'b1;
      controller_ready_flag <= 1'b1;
    end else if (i_seq_done && !controller_ready_flag) begin
      controller_ready_flag <= 1'b1; // RULE15
    end
    if (i_rd_field_end && crc_rd != `DKHRP_CRC_INIT) begin
      crc_err_flag <= 1'b1; // RULE9
      hdr_flag     <= i_rd_is_header;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// fifo shared by dma and serializer
assign fifo_push = (i_dma_rd_valid && !i_dma_rd_parity_err) || rd_word_push;
assign fifo_pop  = i_fifo_pop || wr_word_pop;
assign o_fifo_empty = fifo_count == {(FIFO_AW+1){1'b0}};
assign o_fifo_full  = fifo_count == FIFO_DEPTH[FIFO_AW:0];
assign o_fifo_head  = fifo_mem[fifo_rd_ptr];
assign rd_word = {rd_shift[14:0], i_rd_bit};
always @(posedge i_clk_sys) begin
  if (fifo_push && !o_fifo_full)
    fifo_mem[fifo_wr_ptr] <= rd_word_push ? rd_word :
                             i_dma_rd_data[15:0]; // RULE10
end

always @(posedge i_clk_sys or posedge i_rst) begin
  if (i_rst) begin
    fifo_rd_ptr <= {FIFO_AW{1'b0}};
    fifo_wr_ptr <= {FIFO_AW{1'b0}};
    fifo_count  <= {(FIFO_AW+1){1'b0}};
  end else begin
    if (fifo_push && !o_fifo_full)
      fifo_wr_ptr <= fifo_wr_ptr + 1'b1;
    if (fifo_pop && !o_fifo_empty)
      fifo_rd_ptr <= fifo_rd_ptr + 1'b1;
    case ({fifo_push && !o_fifo_full, fifo_pop && !o_fifo_empty})
      2'b10:   fifo_count <= fifo_count + 1'b1;
      2'b01:   fifo_count <= fifo_count - 1'b1;
      default: fifo_count <= fifo_count;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// write serializer with crc appended
assign wr_word_pop = i_wr_active && i_wr_bit_en && !o_wr_crc_phase &&
                     wr_bit_cnt == `DKHRP_BIT_FIRST && !o_fifo_empty;
always @(posedge i_clk_sys or posedge i_rst) begin
  if (i_rst) begin
    wr_shift       <= `DKHRP_ZERO16;
    wr_bit_cnt     <= `DKHRP_BIT_FIRST;
    crc_wr         <= `DKHRP_CRC_INIT;
    o_wr_bit       <= 1'b0;
    o_wr_crc_phase <= 1'b0;
  end else if (!i_wr_active) begin
    wr_bit_cnt     <= `DKHRP_BIT_FIRST;
    crc_wr         <= `DKHRP_CRC_INIT;
    o_wr_crc_phase <= 1'b0;
  end else if (i_wr_bit_en) begin
    if (o_wr_crc_phase) begin
      o_wr_bit   <= crc_wr[15]; // RULE8
      crc_wr     <= {crc_wr[14:0], 1'b0};
      wr_bit_cnt <= wr_bit_cnt + 1'b1;
    end else if (wr_bit_cnt == `DKHRP_BIT_FIRST && o_fifo_empty) begin
      o_wr_crc_phase <= 1'b1; // RULE8
      o_wr_bit       <= crc_wr[15];
      crc_wr         <= {crc_wr[14:0], 1'b0};
      wr_bit_cnt     <= wr_bit_cnt + 1'b1;
    end else begin
      if (wr_bit_cnt == `DKHRP_BIT_FIRST) begin
        o_wr_bit <= o_fifo_head[15]; // RULE11
        wr_shift <= {o_fifo_head[14:0], 1'b0};
        crc_wr   <= crc_step(crc_wr, o_fifo_head[15]);
      end else begin
        o_wr_bit <= wr_shift[15];
        wr_shift <= {wr_shift[14:0], 1'b0};
        crc_wr   <= crc_step(crc_wr, wr_shift[15]);
      end
      wr_bit_cnt <= wr_bit_cnt + 1'b1;
    end
  end
end

// read deserializer and crc check
assign rd_word_push = i_rd_active && i_rd_bit_en &&
                      rd_bit_cnt == `DKHRP_BIT_LAST; // RULE11
always @(posedge i_clk_sys or posedge i_rst) begin
  if (i_rst) begin
    rd_shift   <= `DKHRP_ZERO16;
    rd_bit_cnt <= `DKHRP_BIT_FIRST;
    crc_rd     <= `DKHRP_CRC_INIT;
  end else if (!i_rd_active) begin
    rd_bit_cnt <= `DKHRP_BIT_FIRST;
    crc_rd     <= `DKHRP_CRC_INIT;
  end else if (i_rd_bit_en) begin
    rd_shift   <= {rd_shift[14:0], i_rd_bit};
    rd_bit_cnt <= rd_bit_cnt + 1'b1;
    crc_rd     <= crc_step(crc_rd, i_rd_bit); // RULE9
  end
end

endmodule

// [testbench/dkhrp_port_asserts.sv]
module dkhrp_port_chk (
  input logic        i_clk_sys,
  input logic        i_rst,
  input logic        i_sync,
  input logic        i_bank_sel_n,
  input logic        i_din,
  input logic        i_dout,
  input logic        i_master_reply_sample,
  input logic [15:0] i_bus_data,
  input logic        i_dma_word_done,
  input logic        i_dma_rd_valid,
  input logic        i_dma_rd_parity_err,
  input logic        o_slave_reply_internal,
  input logic        o_transceiver_transmit_ctl,
  input logic        o_transceiver_receive_ctl,
  input logic        o_slave_register_enable,
  input logic        o_seq_start,
  input logic        o_cmd_abort,
  input logic [21:0] o_dma_address,
  input logic        o_fifo_empty,
  input logic        o_fifo_full
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        sync_q;
  logic        sel_ok;
  logic [15:0] addr_lo;
  assign addr_lo = o_dma_address[15:0];
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // remembers whether the running access selected one of our registers
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sync_q <= 1'h0;
      sel_ok <= 1'h0;
    end else begin
      sync_q <= i_sync;
      if (i_sync && !sync_q)
        sel_ok <= !i_bank_sel_n && (i_bus_data[3:1] <= 3'h4);
    end
  end
  a_write_gets_reply: assert property (
    i_sync && sel_ok && $rose(i_dout) |-> ##[1:2] o_slave_reply_internal)
    else $error("no reply to a write");
  a_read_drives_bus: assert property (
    i_sync && sel_ok && $rose(i_din) |-> ##[1:2] o_transceiver_transmit_ctl)
    else $error("no transmit on a read");
  a_unselected_silent: assert property (
    $rose(i_sync) && i_bank_sel_n |=> !o_slave_reply_internal [*6])
    else $error("reply to an unselected access");
  a_reply_in_access: assert property (
    o_slave_reply_internal |-> $past(i_sync))
    else $error("reply outside a transaction");
  a_tx_rx_opposed: assert property (
    !$past(i_rst) |-> o_transceiver_transmit_ctl != o_transceiver_receive_ctl)
    else $error("transmit and receive not complementary");
  a_start_one_pulse: assert property (
    o_seq_start |-> $past(i_sync) ##1 !o_seq_start)
    else $error("bad sequencer start pulse");
  a_enable_on_sample: assert property (
    !$stable(o_slave_register_enable) |->
      $past(i_master_reply_sample) || $past(i_master_reply_sample, 2))
    else $error("slave enable changed without sample");
  a_parity_aborts: assert property (
    i_dma_rd_valid && i_dma_rd_parity_err |-> ##[1:2] o_cmd_abort)
    else $error("parity error did not abort");
  a_address_steps: assert property (
    i_dma_word_done && !i_sync |=> addr_lo == $past(addr_lo) + 16'h0002)
    else $error("dma address did not advance one word");
  a_fifo_flags_apart: assert property (
    !(o_fifo_empty && o_fifo_full))
    else $error("fifo empty and full together");
  c_write: cover property (o_slave_reply_internal && i_dout);
  c_start: cover property (o_seq_start);
  c_abort: cover property (o_cmd_abort);
endmodule
////////////////////////////////////////////////////////////////////////////
bind dkhrp_port dkhrp_port_chk u_chk (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sync(i_sync),
  .i_bank_sel_n(i_bank_sel_n), .i_din(i_din), .i_dout(i_dout),
  .i_master_reply_sample(i_master_reply_sample),
  .i_bus_data(i_bus_data), .i_dma_word_done(i_dma_word_done),
  .i_dma_rd_valid(i_dma_rd_valid),
  .i_dma_rd_parity_err(i_dma_rd_parity_err),
  .o_slave_reply_internal(o_slave_reply_internal),
  .o_transceiver_transmit_ctl(o_transceiver_transmit_ctl),
  .o_transceiver_receive_ctl(o_transceiver_receive_ctl),
  .o_slave_register_enable(o_slave_register_enable),
  .o_seq_start(o_seq_start), .o_cmd_abort(o_cmd_abort),
  .o_dma_address(o_dma_address), .o_fifo_empty(o_fifo_empty),
  .o_fifo_full(o_fifo_full)
);

// [testbench/dkhrp_host_model.sv]
module dkhrp_host_model (
  input  logic        i_clk,
  input  logic        i_reply,
  input  logic [15:0] i_rdata,
  output logic        o_sync,
  output logic        o_bank_sel_n,
  output logic        o_din,
  output logic        o_dout,
  output logic [15:0] o_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  int hangs = 0;
  initial begin
    o_sync = 1'h0;
    o_bank_sel_n = 1'h1;
    o_din = 1'h0;
    o_dout = 1'h0;
    o_bus = 16'h0000;
  end
  // one register access; ok tells whether a reply came
  task automatic xfer(input logic [2:0] sel, input logic wr,
                      input logic [15:0] wd, input logic bank_n,
                      output logic [15:0] rd, output logic ok);
    int n;
    ok = 1'h0;
    rd = 16'h0000;
    @(negedge i_clk);
    o_bank_sel_n = bank_n;
    o_bus = {12'h000, sel, 1'h0};
    o_sync = 1'h1;
    repeat (2) @(negedge i_clk);
    // a released bus shows the inverse, never a stale value
    o_bus = wr ? wd : ~o_bus;
    o_dout = wr;
    o_din = !wr;
    for (n = 0; n < 6 && !ok; n++) begin
      @(negedge i_clk);
      ok = i_reply === 1'h1;
      rd = i_rdata;
    end
    o_dout = 1'h0;
    o_din = 1'h0;
    for (n = 0; n < 4 && i_reply !== 1'h0; n++)
      @(negedge i_clk);
    if (i_reply !== 1'h0)
      hangs++;
    o_sync = 1'h0;
    o_bank_sel_n = 1'h1;
    o_bus = ~o_bus;
    repeat (2) @(negedge i_clk);
  endtask
endmodule

// [testbench/disk_ctrl_host_register_port_tb.sv]
`include "dkhrp_consts.vh"
module disk_ctrl_host_register_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk_sys = 1'h0;
  logic        i_rst = 1'h1;
  logic        sync, bsel_n, din, dout, reply, tx, rx, sen, start, abort;
  logic        empty, full;
  logic        mrs = 0, wdone = 0, rvalid = 0, perr = 0, sdone = 0;
  logic        ract = 0, ben = 0, rbit = 0, fend = 0, pop = 0;
  logic        wact = 0, wen = 0, wbit, wph;
  logic [1:0]  mode = 2'h0;
  logic [17:0] rdata18 = 18'h00000;
  logic [15:0] bus, bus_out, head;
  logic [2:0]  fcode;
  logic [21:0] addr;
  int          failures = 0, checks_done = 0, starts = 0, aborts = 0;
  always #2 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    starts <= starts + (start === 1'h1);
    aborts <= aborts + (abort === 1'h1);
  end
  dkhrp_host_model host (.i_clk(i_clk_sys), .i_reply(reply),
    .i_rdata(bus_out), .o_sync(sync), .o_bank_sel_n(bsel_n), .o_din(din),
    .o_dout(dout), .o_bus(bus));
  dkhrp_port uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sync(sync),
    .i_bank_sel_n(bsel_n), .i_din(din), .i_dout(dout),
    .i_master_reply_sample(mrs), .i_bus_data(bus), .i_addr_mode(mode),
    .i_drive_ready_bit(1'h1), .i_dma_word_done(wdone),
    .i_dma_rd_valid(rvalid), .i_dma_rd_data(rdata18),
    .i_dma_rd_parity_err(perr), .i_seq_done(sdone), .i_wr_active(wact),
    .i_wr_bit_en(wen), .i_rd_active(ract), .i_rd_bit_en(ben),
    .i_rd_bit(rbit), .i_rd_field_end(fend), .i_rd_is_header(1'h0),
    .i_fifo_pop(pop), .o_bus_data(bus_out), .o_bus_data_oe(),
    .o_slave_reply_internal(reply), .o_transceiver_transmit_ctl(tx),
    .o_transceiver_receive_ctl(rx), .o_slave_register_enable(sen),
    .o_seq_start(start), .o_command_function_code(fcode),
    .o_cmd_abort(abort), .o_dma_address(addr), .o_wr_bit(wbit),
    .o_wr_crc_phase(wph), .o_fifo_head(head), .o_fifo_empty(empty),
    .o_fifo_full(full));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  task automatic wr(input logic [2:0] sel, input logic [15:0] d);
    logic [15:0] r;
    logic        ok;
    host.xfer(sel, 1'h1, d, 1'h0, r, ok);
    chk(ok, 1'h1);
  endtask
  task automatic rd(input logic [2:0] sel, output logic [15:0] v);
    logic ok;
    host.xfer(sel, 1'h0, 16'h0000, 1'h0, v, ok);
    chk(ok, 1'h1);
  endtask
  task automatic sample_ready;
    mrs = 1'h1;
    cyc(1);
    mrs = 1'h0;
    cyc(2);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [15:0] v;
    mode = `DKHRP_MODE_22;
    wr(`DKHRP_SEL_BAR, 16'h1234);
    wr(`DKHRP_SEL_DAR, 16'h5678);
    wr(`DKHRP_SEL_MPR, 16'h0003);
    wr(`DKHRP_SEL_BAE, 16'h0015);
    rd(`DKHRP_SEL_BAR, v);
    chk(v, 16'h1234);
    rd(`DKHRP_SEL_DAR, v);
    chk(v, 16'h5678);
    rd(`DKHRP_SEL_BAE, v);
    chk(v[5:0], 6'h15);
    chk(addr, 22'h151234);
  endtask
  task automatic t_shared;
    logic [15:0] v;
    mode = `DKHRP_MODE_18;
    wr(`DKHRP_SEL_CSR, 16'h00E0);
    rd(`DKHRP_SEL_BAE, v);
    chk(v[1:0], 2'h2);
    rd(`DKHRP_SEL_CSR, v);
    chk({v[7:4], v[0]}, 5'h1D);
    wr(`DKHRP_SEL_BAE, 16'h003D);
    rd(`DKHRP_SEL_CSR, v);
    chk(v[5:4], 2'h1);
    chk(addr[17:16], 2'h1);
    chk(starts, 0);
  endtask
  task automatic t_launch;
    logic [15:0] v;
    wr(`DKHRP_SEL_CSR, 16'h000A);
    cyc(2);
    chk(starts, 1);
    chk(fcode, 3'h5);
    rd(`DKHRP_SEL_CSR, v);
    chk(v[7], 1'h0);
    sample_ready;
    chk(sen, 1'h0);
    wr(`DKHRP_SEL_CSR, 16'h0004);
    cyc(2);
    chk(starts, 1);
    sdone = 1'h1;
    cyc(1);
    sdone = 1'h0;
    cyc(1);
    rd(`DKHRP_SEL_CSR, v);
    chk(v[7], 1'h1);
    sample_ready;
    chk(sen, 1'h1);
  endtask
  task automatic t_parity;
    logic [15:0] v;
    wr(`DKHRP_SEL_CSR, 16'h0002);
    cyc(2);
    chk(starts, 2);
    rdata18 = 18'h30000;
    rvalid = 1'h1;
    perr = 1'h1;
    cyc(1);
    rvalid = 1'h0;
    perr = 1'h0;
    cyc(3);
    chk(aborts, 1);
    rd(`DKHRP_SEL_CSR, v);
    chk({v[15], v[13], v[10], v[7]}, 4'hF);
  endtask
  task automatic t_count;
    mode = `DKHRP_MODE_22;
    wr(`DKHRP_SEL_BAR, 16'hFFFE);
    wr(`DKHRP_SEL_BAE, 16'h0001);
    wdone = 1'h1;
    cyc(1);
    wdone = 1'h0;
    cyc(1);
    chk(addr, 22'h020000);
  endtask
  task automatic t_refuse;
    logic [15:0] v;
    logic        ok;
    host.xfer(`DKHRP_SEL_BAR, 1'h1, 16'hFFFF, 1'h1, v, ok);
    chk(ok, 1'h0);
    host.xfer(3'h5, 1'h0, 16'h0000, 1'h0, v, ok);
    chk(ok, 1'h0);
    rd(`DKHRP_SEL_BAR, v);
    rd(`DKHRP_SEL_BAR, v);
    chk(v, 16'h0000);
  endtask
  task automatic t_serial;
    logic [15:0] v;
    logic [15:0] w;
    int          i;
    w = 16'hA5C3;
    chk(empty, 1'h1);
    ract = 1'h1;
    for (i = 0; i < 32; i++) begin
      rbit = i < 16 ? w[15 - i] : 1'h0;
      ben = 1'h1;
      cyc(1);
      ben = 1'h0;
      cyc(1);
      if (i == 15) begin
        chk(empty, 1'h0);
        chk(head, w);
      end
    end
    fend = 1'h1;
    cyc(1);
    fend = 1'h0;
    ract = 1'h0;
    cyc(2);
    rd(`DKHRP_SEL_CSR, v);
    chk(v[11], 1'h1);
    for (i = 0; i < 4 && empty !== 1'h1; i++) begin
      pop = 1'h1;
      cyc(1);
      pop = 1'h0;
      cyc(1);
    end
    chk(empty, 1'h1);
  endtask
  task automatic t_wserial;
    logic [15:0] w;
    logic [15:0] c;
    logic [31:0] got;
    int          i;
    w = 16'hB2C9;
    c = `DKHRP_CRC_INIT;
    got = 32'h00000000;
    for (i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? `DKHRP_CRC_POLY : 16'h0000);
    rvalid = 1'h1;
    cyc(255);
    chk(full, 1'h0);
    cyc(1);
    chk(full, 1'h1);
    rvalid = 1'h0;
    pop = 1'h1;
    cyc(256);
    pop = 1'h0;
    chk(empty, 1'h1);
    rdata18 = {2'h0, w};
    rvalid = 1'h1;
    cyc(1);
    rvalid = 1'h0;
    wact = 1'h1;
    for (i = 0; i < 32; i++) begin
      wen = 1'h1;
      cyc(1);
      wen = 1'h0;
      got = {got[30:0], wbit};
      if (i == 15 || i == 16)
        chk(wph, i == 16);
      cyc(1);
    end
    wact = 1'h0;
    chk(got[31:16], w);
    chk(got[15:0], c);
    chk(empty, 1'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    failures += host.hangs;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    cyc(3);
    i_rst = 1'h0;
    cyc(2);
    sample_ready;
    chk(sen, 1'h1);
    t_regs;
    t_shared;
    t_launch;
    t_parity;
    t_count;
    t_refuse;
    t_serial;
    t_wserial;
    tally_and_finish;
  end
  initial begin
    #100000;
    failures++;
    tally_and_finish;
  end
endmodule
